// ### dclk_params.svh
// Offsets, field positions, reset values and counts of the clock control.
// Included by the clock control only; the checks and bench use literals; holds definitions only.
`ifndef DCLK_PARAMS_SVH
`define DCLK_PARAMS_SVH
`define OSC_MODE_INDEX    8'hca
`define OSC_STATUS_INDEX  8'hcb
`define OSC_MODE_RESET    8'h00
`define STOP_BIT          1
`define LOW_SEL_BIT       2
`define PMODE_LO          3
`define PMODE_HI          4
`define ST_RUN_BIT        0
`define ST_WARM_BIT       1
`define ST_HOSC_BIT       2
`define ST_LOSC_BIT       3
`define ST_LOW_BIT        4
`define SLOW_DIV          5'h04
`define WAKE_TICKS        12'h800
`define RC_START_TICKS    12'h010
`define XTAL_START_TICKS  12'h800
`endif

// ### dclk_pkg.sv
// Types shared by the clock control, its bound checks and the bench.
// Assumes nothing of its surroundings.
package dclk_pkg;
  typedef enum logic [1:0] {
    PM_NORMAL, PM_SLEEP, PM_GREEN, PM_RESERVED
  } power_mode_t;
  typedef enum logic [2:0] {
    OPT_INT_RC_GPIO, OPT_INT_RC_RTC, OPT_EXT_RC,
    OPT_XTAL_32K, OPT_XTAL_12M, OPT_XTAL_4M
  } high_clk_opt_t;
  typedef enum logic [2:0] {
    S_STARTUP, S_RUN, S_GREEN, S_SLEEP, S_WAKE
  } cpu_state_t;
endpackage

// ### dclk_timing_if.sv
// Carries the divider and warm-up counter signals inside the block.
// Assumes one clock; all signals are synchronous to it.
`timescale 1ns/1ps
interface dclk_timing_if;
  logic        srcTick;
  logic [4:0]  divisor;
  logic        divClear;
  logic        divTick;
  logic        warmStart;
  logic [11:0] warmTicks;
  logic        warmTick;
  logic        warmDone;
  modport ctrl (output srcTick, divisor, divClear, warmStart, warmTicks,
                warmTick, input divTick, warmDone);
  modport divider (input srcTick, divisor, divClear, output divTick);
  modport warmup (input warmStart, warmTicks, warmTick, output warmDone);
endinterface

// ### clock_tick_divider.sv
// Divides a stream of source ticks by a run-time divisor.
// Assumes ticks are one-cycle pulses synchronous to clock.
`timescale 1ns/1ps
module clock_tick_divider (
  input wire logic clock,
  input wire logic rst,
  dclk_timing_if.divider t
);
  logic [3:0] count;

  always_ff @(posedge clock) begin
    if (rst || t.divClear) begin
      count <= 4'h0;
      t.divTick <= 1'b0;
    end else if (t.srcTick) begin
      if ({1'b0, count} == t.divisor - 5'h01) begin
        count <= 4'h0;
        t.divTick <= 1'b1;
      end else begin
        count <= count + 4'h1;
        t.divTick <= 1'b0;
      end
    end else begin
      t.divTick <= 1'b0;
    end
  end
endmodule

// ### osc_warmup_counter.sv
// Counts oscillator ticks after a start request; pulses done at the end.
// Assumes the tick input is a one-cycle pulse per oscillator period.
`timescale 1ns/1ps
module osc_warmup_counter (
  input wire logic clock,
  input wire logic rst,
  dclk_timing_if.warmup w
);
  logic [11:0] count;
  logic        busy;

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= 12'h000;
      busy <= 1'b0;
      w.warmDone <= 1'b0;
    end else if (w.warmStart) begin
      count <= 12'h000;
      busy <= 1'b1;
      w.warmDone <= 1'b0;
    end else if (busy && w.warmTick) begin
      if (count == w.warmTicks - 12'h001) begin
        busy <= 1'b0;
        w.warmDone <= 1'b1;
      end else begin
        count <= count + 12'h001;
        w.warmDone <= 1'b0;
      end
    end else begin
      w.warmDone <= 1'b0;
    end
  end
endmodule

// ### dual_clock_system_control.sv
// Clock selection, instruction clock and power modes of the controller.
// Assumes oscillator ticks arrive as one-cycle pulses synchronous to clock.
//
// What this block does
// - Normal mode instruction ticks are the high clock divided by N, 4..16.
// - Slow mode instruction ticks are the low RC clock divided by four.
// - Mode bit 2 selects high clock (0) or low RC clock (1).
// - Mode bit 1 stops the external high oscillator; low RC keeps running.
// - Mode bits 4:3 code normal, sleep, green and a reserved value.
// - The mode register is at index 0xca, bits 7,6,5,0 read zero, reset 0.
// - Sleep stops both the high oscillator and the low RC oscillator.
// - Low RC stops only in sleep or in green with 32K option and no watchdog.
// - A build option selects the high clock source.
// - With the RTC option the crystal ticks feed timer zero.
// - External clock options take the clock from the input pin.
// - Reset is extended by the high oscillator start-up time.
// - The low RC clock also drives the watchdog.
// - Wakeup from sleep waits 2048 high clock ticks; green needs none.
// - Green halts the CPU, timer zero runs, port or overflow wakes it.
`timescale 1ns/1ps
`include "dclk_params.svh"
module dual_clock_system_control #(
  parameter dclk_pkg::high_clk_opt_t HIGH_CLK_OPTION = dclk_pkg::OPT_XTAL_4M,
  parameter logic [4:0]              CPU_DIV_N       = 5'h04
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        highOscTick,
  input  wire logic        lowRcTick,
  input  wire logic        rtcCrystalTick,
  input  wire logic        portLevelChange,
  input  wire logic        timerZeroOverflow,
  input  wire logic        watchdogEnable,
  output logic             instructionTick,
  output logic             timerZeroTick,
  output logic             watchdogTick,
  output logic             highOscEnable,
  output logic             lowRcEnable,
  output logic             lowClockActive,
  output logic             cpuRun,
  output logic             resetHold,
  output logic             oscInputPinGpio,
  output logic             oscOutputPinGpio,
  output logic             highClockFromPin
);
  dclk_timing_if timing ();

  logic                 ext_hosc_stop;
  logic                 low_clock_select;
  dclk_pkg::power_mode_t cpu_power_mode;
  dclk_pkg::power_mode_t effMode;
  dclk_pkg::cpu_state_t state;
  logic                 warmKick;
  logic                 lowSelSeen;
  logic                 access;
  logic                 hitMode;
  logic                 hitStatus;
  logic                 wakeEvent;
  logic                 greenWake;
  logic                 next_highOscEnable;
  logic                 next_lowRcEnable;
  logic                 isExternal;
  logic                 isRtcOption;
  logic [7:0]           modeRead;
  logic [7:0]           statusRead;

  clock_tick_divider divider (
    .clock (clock),
    .rst   (rst),
    .t     (timing.divider)
  );

  osc_warmup_counter warmup (
    .clock (clock),
    .rst   (rst),
    .w     (timing.warmup)
  );

  assign isExternal  = HIGH_CLK_OPTION != dclk_pkg::OPT_INT_RC_GPIO &&
                       HIGH_CLK_OPTION != dclk_pkg::OPT_INT_RC_RTC;
  assign isRtcOption = HIGH_CLK_OPTION == dclk_pkg::OPT_INT_RC_RTC;

  assign effMode = (cpu_power_mode == dclk_pkg::PM_RESERVED) ?
                   dclk_pkg::PM_NORMAL : cpu_power_mode;

  // APB decode. Registers sit at four times their index.
  assign access    = psel && penable && !pready;
  assign hitMode   = paddr == {2'b00, `OSC_MODE_INDEX, 2'b00};
  assign hitStatus = paddr == {2'b00, `OSC_STATUS_INDEX, 2'b00};

  assign modeRead = {3'b000, cpu_power_mode, low_clock_select,
                     ext_hosc_stop, 1'b0};

  assign statusRead = {3'b000,
                       lowClockActive,
                       lowRcEnable,
                       highOscEnable,
                       state == dclk_pkg::S_STARTUP ||
                       state == dclk_pkg::S_WAKE,
                       cpuRun};

  // Handshake: one wait state, then a one-cycle pready.
  always_ff @(posedge clock) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (access) begin
      pready  <= 1'b1;
      pslverr <= !(hitMode || hitStatus) || (hitStatus && pwrite);
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Read data stands until the next access, so a slow master still sees it.
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (access) begin
      if (!pwrite && hitMode) begin
        prdata <= {24'h000000, modeRead};
      end else if (!pwrite && hitStatus) begin
        prdata <= {24'h000000, statusRead};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  assign greenWake = portLevelChange || timerZeroOverflow;
  assign wakeEvent = (state == dclk_pkg::S_SLEEP && portLevelChange) ||
                     (state == dclk_pkg::S_GREEN && greenWake);

  // Control bits. A wakeup clears the power mode even if a write lands
  // in the same cycle, since the CPU cannot be executing then anyway.
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_hosc_stop    <= 1'(`OSC_MODE_RESET >> `STOP_BIT);
      low_clock_select <= 1'(`OSC_MODE_RESET >> `LOW_SEL_BIT);
      cpu_power_mode   <= dclk_pkg::PM_NORMAL;
    end else begin
      if (access && pwrite && hitMode) begin
        ext_hosc_stop    <= pwdata[`STOP_BIT];
        low_clock_select <= pwdata[`LOW_SEL_BIT];
        cpu_power_mode   <=
          dclk_pkg::power_mode_t'(pwdata[`PMODE_HI:`PMODE_LO]);
      end
      if (wakeEvent) begin
        cpu_power_mode <= dclk_pkg::PM_NORMAL;
      end
    end
  end

  // CPU run state. Start-up and sleep wakeup both wait on high ticks.
  always_ff @(posedge clock) begin
    if (rst) begin
      state    <= dclk_pkg::S_STARTUP;
      warmKick <= 1'b1;
    end else begin
      warmKick <= 1'b0;
      unique case (state)
        dclk_pkg::S_STARTUP: begin
          if (timing.warmDone) begin
            state <= dclk_pkg::S_RUN;
          end
        end
        dclk_pkg::S_RUN: begin
          if (effMode == dclk_pkg::PM_SLEEP) begin
            state <= dclk_pkg::S_SLEEP;
          end else if (effMode == dclk_pkg::PM_GREEN) begin
            state <= dclk_pkg::S_GREEN;
          end
        end
        dclk_pkg::S_GREEN: begin
          if (greenWake) begin
            state <= dclk_pkg::S_RUN;
          end
        end
        dclk_pkg::S_SLEEP: begin
          if (portLevelChange) begin
            state    <= dclk_pkg::S_WAKE;
            warmKick <= 1'b1;
          end
        end
        dclk_pkg::S_WAKE: begin
          if (timing.warmDone) begin
            state <= dclk_pkg::S_RUN;
          end
        end
      endcase
    end
  end

  assign timing.warmStart = warmKick;
  assign timing.warmTicks = (state == dclk_pkg::S_STARTUP) ?
                            ((HIGH_CLK_OPTION == dclk_pkg::OPT_EXT_RC ||
                              !isExternal) ?
                             `RC_START_TICKS : `XTAL_START_TICKS) :
                            `WAKE_TICKS;
  // Warm-up counts raw high ticks; the oscillator is enabled meanwhile.
  assign timing.warmTick  = highOscTick;

  // Divider source. A change of clock select restarts the divider so no
  // short instruction period leaks out at the switch.
  // low RC clock by four when selected, else high clock by N
  assign timing.srcTick  = low_clock_select ? lowRcTick : highOscTick;
  assign timing.divisor  = low_clock_select ? `SLOW_DIV : CPU_DIV_N;
  assign timing.divClear = low_clock_select != lowSelSeen;

  always_ff @(posedge clock) begin
    if (rst) begin
      lowSelSeen <= 1'b0;
    end else begin
      lowSelSeen <= low_clock_select;
    end
  end

  // Oscillator enables.
  always_comb begin
    next_highOscEnable = !ext_hosc_stop;
    next_lowRcEnable   = 1'b1;
    if (state == dclk_pkg::S_SLEEP) begin
      next_highOscEnable = 1'b0;
      next_lowRcEnable   = 1'b0;
    end
    if (state == dclk_pkg::S_GREEN &&
        HIGH_CLK_OPTION == dclk_pkg::OPT_XTAL_32K && !watchdogEnable) begin
      next_lowRcEnable = 1'b0;
    end
    // Warm-up must see high ticks whatever the stop bit says.
    if (state == dclk_pkg::S_STARTUP || state == dclk_pkg::S_WAKE) begin
      next_highOscEnable = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      highOscEnable <= 1'b1;
    end else begin
      highOscEnable <= next_highOscEnable;
    end
  end

  // The low RC has its own flop; it runs on through a high clock stop.
  always_ff @(posedge clock) begin
    if (rst) begin
      lowRcEnable <= 1'b1;
    end else begin
      lowRcEnable <= next_lowRcEnable;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      instructionTick <= 1'b0;
    end else begin
      instructionTick <= timing.divTick && state == dclk_pkg::S_RUN;
    end
  end

  // Timer zero stops only in sleep, so in green it can still wake the CPU.
  always_ff @(posedge clock) begin
    if (rst) begin
      timerZeroTick <= 1'b0;
    end else if (isRtcOption) begin
      timerZeroTick <= rtcCrystalTick && state != dclk_pkg::S_SLEEP;
    end else begin
      timerZeroTick <= timing.divTick && state != dclk_pkg::S_SLEEP;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      watchdogTick <= 1'b0;
    end else begin
      watchdogTick <= lowRcTick && lowRcEnable;
    end
  end

  // Run and hold both decode the state, so they are never high together.
  always_ff @(posedge clock) begin
    if (rst) begin
      cpuRun    <= 1'b0;
      resetHold <= 1'b1;
    end else begin
      cpuRun    <= state == dclk_pkg::S_RUN;
      resetHold <= state == dclk_pkg::S_STARTUP;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lowClockActive <= 1'b0;
    end else begin
      lowClockActive <= low_clock_select;
    end
  end

  // Pin roles follow the build option only.
  always_ff @(posedge clock) begin
    if (rst) begin
      oscInputPinGpio  <= 1'b0;
      oscOutputPinGpio <= 1'b0;
      highClockFromPin <= 1'b0;
    end else begin
      oscInputPinGpio  <= HIGH_CLK_OPTION == dclk_pkg::OPT_INT_RC_GPIO;
      oscOutputPinGpio <= HIGH_CLK_OPTION == dclk_pkg::OPT_INT_RC_GPIO ||
                          HIGH_CLK_OPTION == dclk_pkg::OPT_EXT_RC;
      highClockFromPin <= isExternal;
    end
  end
endmodule

// ### dclk_check_properties.sv
// Concurrent checks on the ports of the clock control.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module dclk_check #(
  parameter dclk_pkg::high_clk_opt_t HIGH_CLK_OPTION = dclk_pkg::OPT_EXT_RC,
  parameter logic [4:0]              CPU_DIV_N       = 5'h04
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        lowRcTick,
  input wire logic        instructionTick,
  input wire logic        watchdogTick,
  input wire logic        highOscEnable,
  input wire logic        lowRcEnable,
  input wire logic        lowClockActive,
  input wire logic        cpuRun,
  input wire logic        resetHold
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_ready_follows: assert property (
    psel && penable && !pready |=> pready)
    else $error("pready did not follow the access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_mode_fixed_bits: assert property (pready && !pwrite &&
    paddr == 12'h328 |-> prdata[31:5] == 27'h0 && !prdata[0])
    else $error("fixed mode bits read non-zero");
  a_low_select: assert property (psel && penable && pwrite && !pready
    && paddr == 12'h328 |-> ##3 lowClockActive == $past(pwdata[2], 3))
    else $error("clock select does not follow the mode write");
  a_tick_spacing: assert property (
    instructionTick |=> !instructionTick [*3])
    else $error("instruction ticks closer than four cycles");
  a_tick_in_run: assert property (
    instructionTick |-> cpuRun || $past(cpuRun))
    else $error("instruction tick while halted");
  a_sleep_both: assert property (!lowRcEnable &&
    HIGH_CLK_OPTION != dclk_pkg::OPT_XTAL_32K |-> !highOscEnable && !cpuRun)
    else $error("low oscillator stopped outside sleep");
  a_hold_no_run: assert property (resetHold |-> !cpuRun)
    else $error("cpu runs during start-up wait");
  a_wdog_source: assert property (
    watchdogTick |-> $past(lowRcTick) && $past(lowRcEnable))
    else $error("watchdog tick without low oscillator tick");
endmodule

bind dual_clock_system_control dclk_check #(
  .HIGH_CLK_OPTION(HIGH_CLK_OPTION),
  .CPU_DIV_N(CPU_DIV_N)
) u_chk (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .lowRcTick(lowRcTick),
  .instructionTick(instructionTick), .watchdogTick(watchdogTick),
  .highOscEnable(highOscEnable), .lowRcEnable(lowRcEnable),
  .lowClockActive(lowClockActive), .cpuRun(cpuRun), .resetHold(resetHold)
);

// ### cpu_bus_model.sv
// CPU-side bus master that reaches the mode register over APB.
// Assumes the slave raises pready; only the bench watchdog ends a wait.
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdata;
  logic        err;
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // Starts on a fresh edge so a release is never overwritten in one step.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the clock control and its bus partner.
// Assumes the external RC option, so start-up waits sixteen high ticks.
`timescale 1ns/1ps
module tb_top;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        hTick, lTick, portChg, tzOvf, wdogEn;
  logic        iTick, wdTick, hEn, lEn, lowAct, run, hold, outGpio;
  logic        tzTick, inGpio, fromPin;
  logic [2:0]  cyc;
  int          error_cnt, cmp_count, n;

  dual_clock_system_control #(
    .HIGH_CLK_OPTION(dclk_pkg::OPT_EXT_RC),
    .CPU_DIV_N(5'h04)
  ) u_dut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .highOscTick(hTick),
    .lowRcTick(lTick), .rtcCrystalTick(1'h0), .portLevelChange(portChg),
    .timerZeroOverflow(tzOvf), .watchdogEnable(wdogEn),
    .instructionTick(iTick), .timerZeroTick(tzTick), .watchdogTick(wdTick),
    .highOscEnable(hEn), .lowRcEnable(lEn), .lowClockActive(lowAct),
    .cpuRun(run), .resetHold(hold), .oscInputPinGpio(inGpio),
    .oscOutputPinGpio(outGpio), .highClockFromPin(fromPin)
  );
  cpu_bus_model u_cpu (
    .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  // High ticks every second cycle, low ticks every eighth; a stopped
  // oscillator gives no ticks at all.
  always @(posedge clock) begin
    cyc <= cyc + 3'h1;
    hTick <= cyc[0] && hEn;
    lTick <= (cyc == 3'h7) && lEn;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cnt(input int sel, input int len);
    n = 0;
    repeat (len) begin
      @(posedge clock);
      n += (sel == 2) ? tzTick : (sel == 1) ? wdTick : iTick;
    end
  endtask
  task automatic waitRun(input int lim);
    n = 0;
    while (run !== 1'h1 && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic pulse(input bit port);
    @(posedge clock);
    if (port) portChg <= 1'h1;
    else tzOvf <= 1'h1;
    @(posedge clock);
    portChg <= 1'h0;
    tzOvf <= 1'h0;
  endtask
  task automatic results;
    $display("mismatches %0d of %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    results;
  end

  initial begin
    {rst, cyc, hTick, lTick, portChg, tzOvf, wdogEn} = 9'h100;
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    waitRun(200);
    chk({31'h0, n >= 30 && n <= 40}, 32'h1);
    chk({31'h0, hold}, 32'h0);
    chk({29'h0, inGpio, outGpio, fromPin}, 32'h3);
    $display("startup done");
    u_cpu.xfer(1'h0, 12'h328, 32'h0);
    chk(u_cpu.rdata, 32'h0);
    u_cpu.xfer(1'h0, 12'h32c, 32'h0);
    chk(u_cpu.rdata, 32'h0000000d);
    u_cpu.xfer(1'h0, 12'h330, 32'h0);
    chk({u_cpu.rdata[30:0], u_cpu.err}, 32'h1);
    u_cpu.xfer(1'h1, 12'h32c, 32'h0);
    chk({31'h0, u_cpu.err}, 32'h1);
    u_cpu.xfer(1'h1, 12'h328, 32'hffffffff);
    u_cpu.xfer(1'h0, 12'h328, 32'h0);
    chk(u_cpu.rdata, 32'h0000001e);
    $display("registers done");
    chk({28'h0, run, lowAct, hEn, lEn}, 32'hd);
    cnt(0, 128);
    chk(32'(n), 32'h4);
    wdogEn <= 1'h1;
    cnt(1, 64);
    chk(32'(n), 32'h8);
    u_cpu.xfer(1'h1, 12'h328, 32'h0);
    repeat (8) @(posedge clock);
    chk({30'h0, lowAct, hEn}, 32'h1);
    cnt(0, 80);
    chk(32'(n), 32'ha);
    $display("clocks done");
    u_cpu.xfer(1'h1, 12'h328, 32'h10);
    repeat (6) @(posedge clock);
    chk({29'h0, run, hEn, lEn}, 32'h3);
    cnt(2, 80);
    chk(32'(n), 32'ha);
    cnt(0, 16);
    chk(32'(n), 32'h0);
    pulse(1'b0);
    waitRun(8);
    chk({31'h0, run}, 32'h1);
    u_cpu.xfer(1'h0, 12'h328, 32'h0);
    chk(u_cpu.rdata, 32'h0);
    $display("green done");
    u_cpu.xfer(1'h1, 12'h328, 32'h08);
    repeat (6) @(posedge clock);
    chk({29'h0, run, hEn, lEn}, 32'h0);
    cnt(2, 32);
    chk(32'(n), 32'h0);
    pulse(1'b0);
    repeat (4) @(posedge clock);
    chk({31'h0, run}, 32'h0);
    pulse(1'b1);
    waitRun(5000);
    chk({31'h0, n >= 4094 && n <= 4104}, 32'h1);
    $display("sleep done");
    results;
  end
endmodule
